/* File: common/rtc_alarm_cal_pkg.sv */
package rtc_alarm_cal_pkg;

  // ==========================================================================
  // Register word indices.
  localparam int             REG_IDX_W           = 3;
  localparam logic [2:0]     IDX_MONTH_DAY       = 3'h0;
  localparam logic [2:0]     IDX_WEEKDAY_HOURS   = 3'h1;
  localparam logic [2:0]     IDX_MINUTES_SECONDS = 3'h2;
  localparam logic [2:0]     IDX_CONTROL         = 3'h3;
  localparam logic [2:0]     IDX_CALIBRATION     = 3'h4;
  localparam logic [2:0]     IDX_IRQ_STATUS      = 3'h5;
  localparam logic [2:0]     IDX_IRQ_MASK        = 3'h6;
  localparam logic [2:0]     IDX_TIMER_STATUS    = 3'h7;

  // ==========================================================================
  // Implemented bits of the alarm value registers.
  localparam logic [15:0]    MONTH_DAY_MASK       = 16'h1f3f;
  localparam logic [15:0]    WEEKDAY_HOURS_MASK   = 16'h073f;
  localparam logic [15:0]    MINUTES_SECONDS_MASK = 16'h7f7f;
  localparam logic [15:0]    ALARM_VALUE_RESET    = 16'h0000;

  // ==========================================================================
  // Digit field positions and widths.
  localparam int             MONTH_TENS_LSB  = 12;
  localparam int             MONTH_TENS_W    = 1;
  localparam int             MONTH_ONES_LSB  = 8;
  localparam int             DAY_TENS_LSB    = 4;
  localparam int             DAY_TENS_W      = 2;
  localparam int             DAY_ONES_LSB    = 0;
  localparam int             WEEKDAY_LSB     = 8;
  localparam int             WEEKDAY_W       = 3;
  localparam int             HOUR_TENS_LSB   = 4;
  localparam int             HOUR_TENS_W     = 2;
  localparam int             HOUR_ONES_LSB   = 0;
  localparam int             MINUTE_TENS_LSB = 12;
  localparam int             MINUTE_ONES_LSB = 8;
  localparam int             SECOND_TENS_LSB = 4;
  localparam int             SECOND_ONES_LSB = 0;
  localparam int             TENS_W          = 3;
  localparam int             ONES_W          = 4;

  // ==========================================================================
  // Control register fields.
  localparam int             CTRL_W            = 6;
  localparam int             CTRL_WRITE_EN_BIT = 0;
  localparam int             CTRL_ALARM_EN_BIT = 1;
  localparam int             CTRL_MASK_LSB     = 2;
  localparam int             CTRL_MASK_W       = 4;
  localparam logic [5:0]     CTRL_RESET        = 6'h00;

  // ==========================================================================
  // Alarm digit mask settings.
  localparam logic [3:0]     MASK_HALF_SECOND = 4'h0;
  localparam logic [3:0]     MASK_SECOND      = 4'h1;
  localparam logic [3:0]     MASK_TEN_SECONDS = 4'h2;
  localparam logic [3:0]     MASK_MINUTE      = 4'h3;
  localparam logic [3:0]     MASK_TEN_MINUTES = 4'h4;
  localparam logic [3:0]     MASK_HOUR        = 4'h5;
  localparam logic [3:0]     MASK_DAY         = 4'h6;
  localparam logic [3:0]     MASK_WEEK        = 4'h7;
  localparam logic [3:0]     MASK_MONTH       = 4'h8;
  localparam logic [3:0]     MASK_YEAR        = 4'h9;

  // ==========================================================================
  // Calibration and timing.
  localparam int             CAL_W              = 8;
  localparam logic [7:0]     CAL_RESET          = 8'h00;
  localparam int             CAL_STEP_SHIFT     = 2;
  localparam int             PRESC_W            = 17;
  localparam int             PULSES_PER_SECOND  = 32768;
  localparam int             SECONDS_PER_MINUTE = 60;
  localparam int             SECONDS_W          = 6;

  // ==========================================================================
  // Interrupt bits.
  localparam int             IRQ_W          = 3;
  localparam int             IRQ_ALARM_BIT  = 0;
  localparam int             IRQ_SECOND_BIT = 1;
  localparam int             IRQ_ADJUST_BIT = 2;
  localparam logic [2:0]     IRQ_RESET      = 3'h0;

endpackage : rtc_alarm_cal_pkg

/* File: common/cal_tick_if.sv */
`timescale 1ns/10ps
interface cal_tick_if;
  logic                                   half_pulse;
  logic                                   second_pulse;
  logic                                   minute_pulse;
  logic [rtc_alarm_cal_pkg::SECONDS_W-1:0] second_count;
  logic [rtc_alarm_cal_pkg::CAL_W-1:0]    cal_value;

  modport source (
    output half_pulse,
    output second_pulse,
    output minute_pulse,
    output second_count,
    input  cal_value
  );

  modport sink (
    input  half_pulse,
    input  second_pulse,
    input  minute_pulse,
    input  second_count,
    output cal_value
  );
endinterface : cal_tick_if

/* File: design/calib_prescaler.sv */
`timescale 1ns/10ps
module calib_prescaler #(
  parameter int PULSES_PER_SECOND = rtc_alarm_cal_pkg::PULSES_PER_SECOND
) (
  // Clock and reset.
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  // Timekeeping pulse pin.
  input  wire logic  i_timekeeping_clk,
  // Tick outputs and calibration input.
  cal_tick_if.source tick
);
  import rtc_alarm_cal_pkg::*;

  // ==========================================================================
  // State.
  typedef struct packed {
    logic [2:0]               sync;
    logic signed [PRESC_W-1:0] count;
    logic [SECONDS_W-1:0]     seconds;
    logic                     half_pulse;
    logic                     second_pulse;
    logic                     minute_pulse;
  } presc_state_t;

  localparam logic signed [PRESC_W-1:0] LAST_COUNT = PRESC_W'(PULSES_PER_SECOND - 1);
  localparam logic signed [PRESC_W-1:0] HALF_COUNT = PRESC_W'(PULSES_PER_SECOND / 2 - 1);
  localparam logic [SECONDS_W-1:0]      LAST_SECOND = SECONDS_W'(SECONDS_PER_MINUTE - 1);

  presc_state_t st;
  presc_state_t next_st;
  logic         tk_edge;
  logic signed [PRESC_W-1:0] scaled_adjust;

  // ==========================================================================
  // Prescaler with once-per-minute adjustment.
  always_comb
  begin
    next_st = st;
    next_st.sync = {st.sync[1:0], i_timekeeping_clk};
    next_st.half_pulse = 1'b0;
    next_st.second_pulse = 1'b0;
    next_st.minute_pulse = 1'b0;
    tk_edge = st.sync[1] & ~st.sync[2];
    scaled_adjust = PRESC_W'(signed'(tick.cal_value)) <<< CAL_STEP_SHIFT;
    if (tk_edge)
    begin
      if (st.count >= LAST_COUNT)
      begin
        next_st.second_pulse = 1'b1;
        if (st.seconds == LAST_SECOND)
        begin
          next_st.seconds = '0;
          next_st.minute_pulse = 1'b1;
          // A negative start lengthens the next second, a positive start shortens it.
          next_st.count = scaled_adjust;
        end
        else
        begin
          next_st.seconds = st.seconds + SECONDS_W'(1);
          next_st.count = '0;
        end
      end
      else
      begin
        next_st.count = st.count + PRESC_W'(1);
        next_st.half_pulse = (st.count == HALF_COUNT);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign tick.half_pulse   = st.half_pulse;
  assign tick.second_pulse = st.second_pulse;
  assign tick.minute_pulse = st.minute_pulse;
  assign tick.second_count = st.seconds;

endmodule : calib_prescaler

/* File: design/rtc_alarm_cal_top.sv */
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module rtc_alarm_cal_top #(
  parameter int PULSES_PER_SECOND = rtc_alarm_cal_pkg::PULSES_PER_SECOND
) (
  // Clock and reset.
  input  wire logic                                   i_clk,
  input  wire logic                                   i_rst_n,
  // Avalon-MM register slave.
  input  wire logic [rtc_alarm_cal_pkg::REG_IDX_W-1:0] i_avs_address,
  input  wire logic                                   i_avs_read,
  input  wire logic                                   i_avs_write,
  input  wire logic [31:0]                            i_avs_writedata,
  input  wire logic [3:0]                             i_avs_byteenable,
  output logic      [31:0]                            o_avs_readdata,
  output logic                                        o_avs_waitrequest,
  // Timekeeping pulse pin.
  input  wire logic                                   i_timekeeping_clk,
  // Current clock digits from the timekeeping registers.
  input  wire logic [15:0]                            i_now_month_day,
  input  wire logic [15:0]                            i_now_weekday_hours,
  input  wire logic [15:0]                            i_now_minutes_seconds,
  // Events.
  output logic                                        o_alarm_event,
  output logic                                        o_irq
);
  import rtc_alarm_cal_pkg::*;

  // ==========================================================================
  // State.
  typedef struct packed {
    logic                 ack;
    logic [31:0]          readdata;
    logic [15:0]          month_day;
    logic [15:0]          weekday_hours;
    logic [15:0]          minutes_seconds;
    logic [CTRL_W-1:0]    ctrl;
    logic [CAL_W-1:0]     cal;
    logic [IRQ_W-1:0]     irq_status;
    logic [IRQ_W-1:0]     irq_mask;
    logic                 alarm_pulse;
  } top_state_t;

  top_state_t st;
  top_state_t next_st;
  cal_tick_if tick ();

  // ==========================================================================
  // Helpers.
  function automatic logic [15:0] merge16(
    input logic [15:0] old_value,
    input logic [31:0] wdata,
    input logic [3:0]  be,
    input logic [15:0] keep_mask
  );
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}};
    merge16 = ((old_value & ~lanes) | (wdata[15:0] & lanes)) & keep_mask;
  endfunction : merge16

  function automatic logic ones_eq(
    input logic [15:0] a,
    input logic [15:0] b,
    input int          lsb
  );
    ones_eq = (a[lsb +: ONES_W] == b[lsb +: ONES_W]);
  endfunction : ones_eq

  function automatic logic tens_eq(
    input logic [15:0] a,
    input logic [15:0] b,
    input int          lsb
  );
    tens_eq = (a[lsb +: TENS_W] == b[lsb +: TENS_W]);
  endfunction : tens_eq

  // ==========================================================================
  // Prescaler and calibration.
  calib_prescaler #(
    .PULSES_PER_SECOND (PULSES_PER_SECOND)
  ) u_prescaler (
    .i_clk             (i_clk),
    .i_rst_n           (i_rst_n),
    .i_timekeeping_clk (i_timekeeping_clk),
    .tick              (tick.source)
  );

  assign tick.cal_value = st.cal;

  // ==========================================================================
  // Alarm comparison.
  logic [15:0]           now_md;
  logic [15:0]           now_wh;
  logic [15:0]           now_ms;
  logic [CTRL_MASK_W-1:0] digit_mask;
  logic                  m_sec_one;
  logic                  m_sec_ten;
  logic                  m_min_one;
  logic                  m_min_ten;
  logic                  m_hour;
  logic                  m_weekday;
  logic                  m_day;
  logic                  m_month;
  logic                  digits_match;
  logic                  alarm_hit;

  always_comb
  begin
    now_md = i_now_month_day & MONTH_DAY_MASK;
    now_wh = i_now_weekday_hours & WEEKDAY_HOURS_MASK;
    now_ms = i_now_minutes_seconds & MINUTES_SECONDS_MASK;
    digit_mask = st.ctrl[CTRL_MASK_LSB +: CTRL_MASK_W];
    m_sec_one = ones_eq(st.minutes_seconds, now_ms, SECOND_ONES_LSB);
    m_sec_ten = tens_eq(st.minutes_seconds, now_ms, SECOND_TENS_LSB);
    m_min_one = ones_eq(st.minutes_seconds, now_ms, MINUTE_ONES_LSB);
    m_min_ten = tens_eq(st.minutes_seconds, now_ms, MINUTE_TENS_LSB);
    m_hour = ones_eq(st.weekday_hours, now_wh, HOUR_ONES_LSB)
           & (st.weekday_hours[HOUR_TENS_LSB +: HOUR_TENS_W]
              == now_wh[HOUR_TENS_LSB +: HOUR_TENS_W]);
    m_weekday = (st.weekday_hours[WEEKDAY_LSB +: WEEKDAY_W]
                 == now_wh[WEEKDAY_LSB +: WEEKDAY_W]);
    m_day = ones_eq(st.month_day, now_md, DAY_ONES_LSB)
          & (st.month_day[DAY_TENS_LSB +: DAY_TENS_W]
             == now_md[DAY_TENS_LSB +: DAY_TENS_W]);
    m_month = ones_eq(st.month_day, now_md, MONTH_ONES_LSB)
            & (st.month_day[MONTH_TENS_LSB +: MONTH_TENS_W]
               == now_md[MONTH_TENS_LSB +: MONTH_TENS_W]);
    digits_match = 1'b0;
    case (digit_mask)
      MASK_SECOND:      digits_match = 1'b1;
      MASK_TEN_SECONDS: digits_match = m_sec_one;
      MASK_MINUTE:      digits_match = m_sec_one & m_sec_ten;
      MASK_TEN_MINUTES: digits_match = m_sec_one & m_sec_ten & m_min_one;
      MASK_HOUR:        digits_match = m_sec_one & m_sec_ten & m_min_one & m_min_ten;
      MASK_DAY:         digits_match = m_sec_one & m_sec_ten & m_min_one & m_min_ten & m_hour;
      MASK_WEEK:        digits_match = m_sec_one & m_sec_ten & m_min_one & m_min_ten & m_hour
                                     & m_weekday;
      MASK_MONTH:       digits_match = m_sec_one & m_sec_ten & m_min_one & m_min_ten & m_hour
                                     & m_day;
      MASK_YEAR:        digits_match = m_sec_one & m_sec_ten & m_min_one & m_min_ten & m_hour
                                     & m_day & m_month;
      default:          digits_match = 1'b0;
    endcase
    if (digit_mask == MASK_HALF_SECOND)
    begin
      alarm_hit = st.ctrl[CTRL_ALARM_EN_BIT] & (tick.half_pulse | tick.second_pulse);
    end
    else
    begin
      alarm_hit = st.ctrl[CTRL_ALARM_EN_BIT] & tick.second_pulse & digits_match;
    end
  end

  // ==========================================================================
  // Register file and bus slave.
  logic             req;
  logic             wr;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] w1c;
  logic [31:0]      rd_value;

  always_comb
  begin
    next_st = st;
    req = i_avs_read | i_avs_write;
    wr = i_avs_write & st.ack;
    next_st.ack = req & ~st.ack;
    rd_value = 32'h0000_0000;
    unique case (i_avs_address)
      IDX_MONTH_DAY:       rd_value = {16'h0000, st.month_day};
      IDX_WEEKDAY_HOURS:   rd_value = {16'h0000, st.weekday_hours};
      IDX_MINUTES_SECONDS: rd_value = {16'h0000, st.minutes_seconds};
      IDX_CONTROL:         rd_value = {26'h000_0000, st.ctrl};
      IDX_CALIBRATION:     rd_value = {24'h00_0000, st.cal};
      IDX_IRQ_STATUS:      rd_value = {29'h0000_0000, st.irq_status};
      IDX_IRQ_MASK:        rd_value = {29'h0000_0000, st.irq_mask};
      IDX_TIMER_STATUS:    rd_value = {26'h000_0000, tick.second_count};
    endcase
    if (i_avs_read & ~st.ack)
    begin
      next_st.readdata = rd_value;
    end
    w1c = '0;
    if (wr)
    begin
      unique case (i_avs_address)
        IDX_MONTH_DAY:
        begin
          if (st.ctrl[CTRL_WRITE_EN_BIT])
          begin
            next_st.month_day = merge16(st.month_day, i_avs_writedata, i_avs_byteenable,
                                        MONTH_DAY_MASK);
          end
        end
        IDX_WEEKDAY_HOURS:
        begin
          if (st.ctrl[CTRL_WRITE_EN_BIT])
          begin
            next_st.weekday_hours = merge16(st.weekday_hours, i_avs_writedata,
                                            i_avs_byteenable, WEEKDAY_HOURS_MASK);
          end
        end
        IDX_MINUTES_SECONDS:
        begin
          next_st.minutes_seconds = merge16(st.minutes_seconds, i_avs_writedata,
                                            i_avs_byteenable, MINUTES_SECONDS_MASK);
        end
        IDX_CONTROL:
        begin
          if (i_avs_byteenable[0])
          begin
            next_st.ctrl = i_avs_writedata[CTRL_W-1:0];
          end
        end
        IDX_CALIBRATION:
        begin
          if (i_avs_byteenable[0])
          begin
            next_st.cal = i_avs_writedata[CAL_W-1:0];
          end
        end
        IDX_IRQ_STATUS:
        begin
          if (i_avs_byteenable[0])
          begin
            w1c = i_avs_writedata[IRQ_W-1:0];
          end
        end
        IDX_IRQ_MASK:
        begin
          if (i_avs_byteenable[0])
          begin
            next_st.irq_mask = i_avs_writedata[IRQ_W-1:0];
          end
        end
        IDX_TIMER_STATUS:
        begin
          next_st.irq_mask = st.irq_mask;
        end
      endcase
    end
    events = '0;
    events[IRQ_ALARM_BIT] = alarm_hit;
    events[IRQ_SECOND_BIT] = tick.second_pulse;
    events[IRQ_ADJUST_BIT] = tick.minute_pulse;
    next_st.irq_status = (st.irq_status & ~w1c) | events;
    next_st.alarm_pulse = alarm_hit;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st.ack <= 1'b0;
      st.readdata <= 32'h0000_0000;
      st.month_day <= ALARM_VALUE_RESET;
      st.weekday_hours <= ALARM_VALUE_RESET;
      st.minutes_seconds <= ALARM_VALUE_RESET;
      st.ctrl <= CTRL_RESET;
      st.cal <= CAL_RESET;
      st.irq_status <= IRQ_RESET;
      st.irq_mask <= IRQ_RESET;
      st.alarm_pulse <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs.
  assign o_avs_waitrequest = req & ~st.ack;
  assign o_avs_readdata = st.readdata;
  assign o_alarm_event = st.alarm_pulse;
  assign o_irq = |(st.irq_status & st.irq_mask);

endmodule : rtc_alarm_cal_top

/* File: testbench/rtc_alarm_cal_assertions.sv */
`timescale 1ns/10ps
// ==========================================
// Bus handshake, register read and alarm event pulse checks.
module rtc_alarm_cal_checker #(
  parameter int PULSES_PER_SECOND = rtc_alarm_cal_pkg::PULSES_PER_SECOND
) (
  input wire logic                                    i_clk,
  input wire logic                                    i_rst_n,
  input wire logic [rtc_alarm_cal_pkg::REG_IDX_W-1:0] i_avs_address,
  input wire logic                                    i_avs_read,
  input wire logic                                    i_avs_write,
  input wire logic [31:0]                             o_avs_readdata,
  input wire logic                                    o_avs_waitrequest,
  input wire logic                                    o_alarm_event
);
  import rtc_alarm_cal_pkg::*;

  logic req;
  logic rd_done;

  assign req     = i_avs_read | i_avs_write;
  assign rd_done = i_avs_read & ~o_avs_waitrequest;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_idle_no_wait;
    !req |-> !o_avs_waitrequest;
  endproperty
  a_idle_no_wait: assert property (p_idle_no_wait) else $error("wait while idle");

  property p_one_wait;
    req && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");

  property p_b2b_wait;
    (req && !o_avs_waitrequest) ##1 req |-> o_avs_waitrequest;
  endproperty
  a_b2b_wait: assert property (p_b2b_wait) else $error("back to back without wait");

  property p_md_zero;
    rd_done && i_avs_address == IDX_MONTH_DAY |-> (o_avs_readdata & ~{16'h0, MONTH_DAY_MASK}) == 0;
  endproperty
  a_md_zero: assert property (p_md_zero) else $error("month day spare bits set");

  property p_wh_zero;
    rd_done && i_avs_address == IDX_WEEKDAY_HOURS
      |-> (o_avs_readdata & ~{16'h0, WEEKDAY_HOURS_MASK}) == 0;
  endproperty
  a_wh_zero: assert property (p_wh_zero) else $error("weekday hours spare bits set");

  property p_ms_zero;
    rd_done && i_avs_address == IDX_MINUTES_SECONDS
      |-> (o_avs_readdata & ~{16'h0, MINUTES_SECONDS_MASK}) == 0;
  endproperty
  a_ms_zero: assert property (p_ms_zero) else $error("min sec spare bits set");

  property p_cal_zero;
    rd_done && i_avs_address == IDX_CALIBRATION |-> o_avs_readdata[31:8] == 24'h0;
  endproperty
  a_cal_zero: assert property (p_cal_zero) else $error("calibration upper bits set");

  property p_event_pulse;
    o_alarm_event |=> !o_alarm_event [*3];
  endproperty
  a_event_pulse: assert property (p_event_pulse) else $error("alarm event too long");

  property p_rdata_hold;
    !i_avs_read |=> $stable(o_avs_readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed unasked");
endmodule : rtc_alarm_cal_checker

bind rtc_alarm_cal_top rtc_alarm_cal_checker #(
  .PULSES_PER_SECOND(PULSES_PER_SECOND)
) u_checker (
  .i_clk            (i_clk),
  .i_rst_n          (i_rst_n),
  .i_avs_address    (i_avs_address),
  .i_avs_read       (i_avs_read),
  .i_avs_write      (i_avs_write),
  .o_avs_readdata   (o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .o_alarm_event    (o_alarm_event)
);

/* File: testbench/tb.sv */
`timescale 1ns/10ps
// ==========================================
// Register, alarm and calibration bench.
module tb;
  import rtc_alarm_cal_pkg::*;
  localparam int PPS = 8;
  logic        clk;
  logic        rst_n;
  logic [2:0]  addr;
  logic        rd_req;
  logic        wr_req;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        wait_req;
  logic        tk;
  logic [1:0]  tk_div;
  logic [15:0] now_ms;
  logic        alarm_ev;
  logic        irq;
  int          errors;
  int          check_count;
  int          cycles;
  int          tk_pulses;

  rtc_alarm_cal_top #(.PULSES_PER_SECOND(PPS)) dut (
    .i_clk                (clk),
    .i_rst_n              (rst_n),
    .i_avs_address        (addr),
    .i_avs_read           (rd_req),
    .i_avs_write          (wr_req),
    .i_avs_writedata      (wdata),
    .i_avs_byteenable     (be),
    .o_avs_readdata       (rdata),
    .o_avs_waitrequest    (wait_req),
    .i_timekeeping_clk    (tk),
    .i_now_month_day      (16'h0101),
    .i_now_weekday_hours  (16'h0312),
    .i_now_minutes_seconds(now_ms),
    .o_alarm_event        (alarm_ev),
    .o_irq                (irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Timekeeping pin toggles every 4 clocks and its rising edges are counted.
  always @(posedge clk)
  begin
    tk_div <= tk_div + 2'h1;
    if (tk_div == 2'h3)
    begin
      tk <= ~tk;
      if (!tk) tk_pulses <= tk_pulses + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n = 0;
    @(posedge clk);
    wr_req <= w;
    rd_req <= !w;
    addr <= a;
    wdata <= d;
    be <= b;
    do
    begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 20);
    chk({31'h0, wait_req}, 32'h0);
    q = rdata;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
  endtask : bus

  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(q, exp);
  endtask : rd

  task automatic t_gate();
    logic [15:0] msk [3] = '{MONTH_DAY_MASK, WEEKDAY_HOURS_MASK, MINUTES_SECONDS_MASK};
    logic [15:0] val [3] = '{16'h1231, 16'h0623, 16'h5959};
    logic [31:0] q;
    for (int i = 0; i < 8; i++) rd(3'(i), 32'h0);
    wr(IDX_MONTH_DAY, 32'hffff);
    rd(IDX_MONTH_DAY, 32'h0);
    wr(IDX_WEEKDAY_HOURS, 32'hffff);
    rd(IDX_WEEKDAY_HOURS, 32'h0);
    wr(IDX_CONTROL, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      wr(3'(i), 32'hffffffff);
      rd(3'(i), {16'h0, msk[i]});
      wr(3'(i), {16'h0, val[i]});
      rd(3'(i), {16'h0, val[i]});
    end
    bus(1'b1, IDX_MINUTES_SECONDS, 32'hffff, 4'h1, q);
    rd(IDX_MINUTES_SECONDS, 32'h597f);
    wr(IDX_CALIBRATION, 32'hfffffffe);
    rd(IDX_CALIBRATION, 32'hfe);
  endtask : t_gate

  task automatic wait_ev(output logic seen);
    seen = 1'b0;
    repeat (200)
    begin
      @(posedge clk);
      if (alarm_ev === 1'b1) seen = 1'b1;
    end
  endtask : wait_ev

  task automatic t_alarm();
    logic seen;
    wr(IDX_MINUTES_SECONDS, 32'h0012);
    now_ms <= 16'h0012;
    wr(IDX_IRQ_MASK, 32'h1);
    wr(IDX_CONTROL, 32'h0f);
    wait_ev(seen);
    chk({31'h0, seen}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    now_ms <= 16'h0013;
    wr(IDX_IRQ_MASK, 32'h1);
    wr(IDX_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wait_ev(seen);
    chk({31'h0, seen}, 32'h0);
    wr(IDX_CONTROL, 32'h1);
  endtask : t_alarm

  task automatic t_b2b();
    int n = 0;
    @(posedge clk);
    rd_req <= 1'b1;
    addr <= IDX_CALIBRATION;
    do
    begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 20);
    chk(rdata, 32'hfe);
    addr <= IDX_MINUTES_SECONDS;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 20);
    chk(rdata, 32'h597f);
    rd_req <= 1'b0;
  endtask : t_b2b

  task automatic t_masks();
    logic seen;
    wr(IDX_MONTH_DAY, 32'h0201);
    wr(IDX_WEEKDAY_HOURS, 32'h0312);
    wr(IDX_MINUTES_SECONDS, 32'h0012);
    now_ms <= 16'h0012;
    for (int m = 0; m < 16; m++)
    begin
      wr(IDX_CONTROL, 32'(m * 4 + 3));
      wait_ev(seen);
      wr(IDX_CONTROL, 32'h1);
      chk({31'h0, seen}, {31'h0, m < 9});
    end
  endtask : t_masks

  task automatic wait_min(output int p);
    int n = 0;
    while (irq !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    p = tk_pulses;
    wr(IDX_IRQ_STATUS, 32'h4);
    repeat (2) @(posedge clk);
    rd(IDX_TIMER_STATUS, 32'h0);
  endtask : wait_min

  task automatic t_cal(input logic [7:0] c, input int exp);
    int a;
    int b;
    wr(IDX_CALIBRATION, {24'h0, c});
    wr(IDX_IRQ_MASK, 32'h4);
    wr(IDX_IRQ_STATUS, 32'h7);
    wait_min(a);
    wait_min(b);
    chk(32'(b - a), 32'(exp));
  endtask : t_cal

  initial
  begin
    rst_n = 1'b0;
    rd_req = 1'b0;
    wr_req = 1'b0;
    addr = 3'h0;
    wdata = 32'h0;
    be = 4'hf;
    tk = 1'b0;
    tk_div = 2'h0;
    now_ms = 16'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_gate();
    t_b2b();
    t_alarm();
    t_masks();
    t_cal(8'h01, 60 * PPS - 4);
    t_cal(8'hfe, 60 * PPS + 8);
    print_verdict();
  end
endmodule : tb
